// file: rtl/suq_defs.vh
`ifndef SUQ_DEFS_VH
`define SUQ_DEFS_VH

// Command bytes
`define SUQ_CMD_STATUS     8'h01
`define SUQ_CMD_FLAGS_CLR  8'h08
`define SUQ_CMD_FLAGS      8'h09
`define SUQ_CMD_NEXT_MSG   8'h93
`define SUQ_CMD_SEND       8'hB0
`define SUQ_CMD_LOAD       8'hC0
`define SUQ_CMD_READBACK   8'hC1

// Filler byte driven when nothing is returned
`define SUQ_FILLER         8'h00

// Load queue geometry
`define SUQ_QDEPTH         32
`define SUQ_QAW            5
`define SUQ_QLAST          8'h1F
`define SUQ_QFULL          9'h020

// Receive buffer geometry
`define SUQ_RXF_WIDTH      9
`define SUQ_RXF_DEPTH      8
`define SUQ_RXF_AW         3

// Receive state register fields
`define SUQ_STAT_EMPTY     0
`define SUQ_STAT_STOP      1
`define SUQ_STAT_TXBUSY    2
`define SUQ_STAT_RESET     8'h01

// Receive event flags register fields
`define SUQ_FLAG_RXERR     0
`define SUQ_FLAG_QOVF      2
`define SUQ_FLAG_RESET     8'h00

`endif

// file: rtl/suq_top.v
// Behaviour
// - C0h then length byte then that many bytes, at most 32, are stored in the load queue.
// - B0h starts sending the queued message onto the UART chain.
// - 01h returns receive state; host polls bit 1 with a timeout.
// - 93h shifts out the next received message in arrival order.
// - 09h returns receive event flags; zero means no receive errors.
// - Sent broadcast write returns unchanged except for the alive counter.
// - Each chain member increments the alive counter once when enabled.
// - Returned read: echo, member data farthest first, data-check, check, alive.
// - C1h returns the stored length then the stored message bytes.
// - State bit 1 is set while a complete stopped message is buffered.
`timescale 1ns/1ps
`default_nettype none
`include "suq_defs.vh"

////////////////////////////////////////////////////////////////////////////////
module suq_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk,
    input  wire             rstn,
    input  wire             in_valid,
    output reg              in_ready,
    input  wire [WIDTH-1:0] in_data,
    output reg              out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr;
    reg  [AW-1:0]    rd_ptr;
    reg  [AW:0]      count;
    wire             push = in_valid & in_ready;
    wire             pop  = out_valid & out_ready;
    reg  [AW:0]      next_count;

    assign out_data = mem[rd_ptr];

    always @* begin
        next_count = count;
        if (push & ~pop)
            next_count = count + 1'b1;
        else if (pop & ~push)
            next_count = count - 1'b1;
    end

    always @(posedge clk) begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr    <= {AW{1'b0}};
            rd_ptr    <= {AW{1'b0}};
            count     <= {(AW+1){1'b0}};
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            count     <= next_count;
            in_ready  <= (next_count != DEPTH[AW:0]);
            out_valid <= (next_count != {(AW+1){1'b0}});
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module suq_top (
    input  wire       clk,
    input  wire       rstn,
    input  wire       cs_n,
    input  wire       sclk,
    input  wire       mosi,
    output reg        miso,
    output reg        tx_valid,
    input  wire       tx_ready,
    output reg  [7:0] tx_data,
    output reg        tx_last,
    input  wire       rx_valid,
    output wire       rx_ready,
    input  wire [7:0] rx_data,
    input  wire       rx_stop,
    input  wire       rx_err
);
    // SPI framing state
    reg        sclk_q;
    reg  [2:0] bit_cnt;
    reg  [8:0] bcnt;
    reg  [7:0] in_sh;
    reg  [7:0] out_sh;
    reg  [7:0] cmd;
    reg        msg_done;

    // Load queue and transmit state
    reg  [7:0] qmem [0:`SUQ_QDEPTH-1];
    reg  [7:0] q_len;
    reg        tx_busy;
    reg  [7:0] tx_idx;

    // Receive side state
    reg  [3:0] msg_cnt;
    reg  [7:0] flags;

    wire       f_in_ready;
    wire       f_out_valid;
    wire [8:0] f_out_data;

    wire       sclk_rise = ~cs_n & sclk & ~sclk_q;
    wire       sclk_fall = ~cs_n & ~sclk & sclk_q;
    wire [7:0] in_byte   = {in_sh[6:0], mosi};
    wire       byte_done = sclk_rise & (bit_cnt == 3'h7);
    wire [7:0] cur_cmd   = (bcnt == 9'h000) ? in_byte : cmd;
    wire [8:0] rb_idx    = bcnt - 9'h001;
    wire [8:0] wr_idx    = bcnt - 9'h002;

    wire       rx_push   = rx_valid & f_in_ready;
    wire       push_last = rx_push & rx_stop;

    reg  [7:0] next_out;
    reg        pop;
    wire       pop_last  = pop & f_out_data[8];

    wire [7:0] status = {5'h00, tx_busy, (msg_cnt != 4'h0), ~f_out_valid};

    wire [7:0] flag_set;
    assign flag_set = {5'h00,
                       (byte_done & (cmd == `SUQ_CMD_LOAD) & ~tx_busy &
                        (bcnt >= 9'h002) & (wr_idx < {1'b0, q_len}) &
                        (wr_idx >= `SUQ_QFULL)),
                       1'b0,
                       (rx_push & rx_err)};

    assign rx_ready = f_in_ready;

    ////////////////////////////////////////////////////////////////////////////
    // Receive buffer
    suq_fifo #(
        .WIDTH (`SUQ_RXF_WIDTH),
        .DEPTH (`SUQ_RXF_DEPTH),
        .AW    (`SUQ_RXF_AW)
    ) u_rx_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (rx_valid),
        .in_ready  (f_in_ready),
        .in_data   ({rx_stop, rx_data}),
        .out_valid (f_out_valid),
        .out_ready (pop),
        .out_data  (f_out_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Byte to return after the one just completed
    always @* begin
        next_out = `SUQ_FILLER;
        pop      = 1'b0;
        case (cur_cmd)
            `SUQ_CMD_STATUS: begin
                next_out = status;
            end
            `SUQ_CMD_FLAGS: begin
                next_out = flags;
            end
            `SUQ_CMD_READBACK: begin
                if (bcnt == 9'h000)
                    next_out = q_len;
                else if ((rb_idx < {1'b0, q_len}) && (rb_idx < `SUQ_QFULL))
                    next_out = qmem[rb_idx[`SUQ_QAW-1:0]];
            end
            `SUQ_CMD_NEXT_MSG: begin
                if (~msg_done & f_out_valid) begin
                    next_out = f_out_data[7:0];
                    pop      = byte_done;
                end
            end
            default: begin
                next_out = `SUQ_FILLER;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // SPI serial engine
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclk_q   <= 1'b0;
            bit_cnt  <= 3'h0;
            bcnt     <= 9'h000;
            in_sh    <= 8'h00;
            out_sh   <= `SUQ_FILLER;
            cmd      <= 8'h00;
            msg_done <= 1'b0;
            miso     <= 1'b0;
        end else begin
            sclk_q <= sclk;
            if (cs_n) begin
                bit_cnt  <= 3'h0;
                bcnt     <= 9'h000;
                out_sh   <= `SUQ_FILLER;
                msg_done <= 1'b0;
                miso     <= 1'b0;
            end else begin
                if (sclk_rise) begin
                    in_sh   <= in_byte;
                    bit_cnt <= bit_cnt + 3'h1;
                end
                if (byte_done) begin
                    if (bcnt == 9'h000)
                        cmd <= in_byte;
                    if (bcnt != 9'h1FF)
                        bcnt <= bcnt + 9'h001;
                    out_sh <= next_out;
                    if (pop_last)
                        msg_done <= 1'b1;
                end else if (sclk_fall) begin
                    miso   <= out_sh[7];
                    out_sh <= {out_sh[6:0], 1'b0};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Load queue storage, refused while a send is running
    always @(posedge clk) begin
        if (byte_done && (cmd == `SUQ_CMD_LOAD) && !tx_busy &&
            (bcnt >= 9'h002) && (wr_idx < {1'b0, q_len}) &&
            (wr_idx < `SUQ_QFULL))
            qmem[wr_idx[`SUQ_QAW-1:0]] <= in_byte;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Queue length and transmit stream
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q_len    <= 8'h00;
            tx_busy  <= 1'b0;
            tx_idx   <= 8'h00;
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
            tx_last  <= 1'b0;
        end else begin
            if (byte_done && (cmd == `SUQ_CMD_LOAD) && !tx_busy &&
                (bcnt == 9'h001))
                q_len <= in_byte;
            if (byte_done && (bcnt == 9'h000) &&
                (in_byte == `SUQ_CMD_SEND) && !tx_busy &&
                (q_len != 8'h00)) begin
                tx_busy <= 1'b1;
                tx_idx  <= 8'h00;
            end else if (tx_busy && (!tx_valid || tx_ready)) begin
                if ((tx_idx < q_len) && (tx_idx <= `SUQ_QLAST)) begin
                    tx_valid <= 1'b1;
                    tx_data  <= qmem[tx_idx[`SUQ_QAW-1:0]];
                    tx_last  <= ((tx_idx + 8'h01) == q_len) ||
                                (tx_idx == `SUQ_QLAST);
                    tx_idx   <= tx_idx + 8'h01;
                end else begin
                    tx_valid <= 1'b0;
                    tx_last  <= 1'b0;
                    tx_busy  <= 1'b0;
                end
            end else if (tx_valid && tx_ready) begin
                tx_valid <= 1'b0;
                tx_last  <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Message count and event flags
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            msg_cnt <= 4'h0;
            flags   <= `SUQ_FLAG_RESET;
        end else begin
            if (push_last & ~pop_last)
                msg_cnt <= msg_cnt + 4'h1;
            else if (pop_last & ~push_last)
                msg_cnt <= msg_cnt - 4'h1;
            // Write-one-to-clear; a new event in the same cycle is kept
            if (byte_done && (cmd == `SUQ_CMD_FLAGS_CLR) && (bcnt == 9'h001))
                flags <= (flags & ~in_byte) | flag_set;
            else
                flags <= flags | flag_set;
        end
    end
endmodule
`default_nettype wire

// file: sim/suq_chain_model.sv
`timescale 1ns/1ps
`default_nettype none
module suq_chain_model #(
    parameter int MEMBERS = 2
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       slow,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    output var  logic       tx_ready,
    output var  logic       rx_valid,
    input  wire logic       rx_ready,
    output var  logic [7:0] rx_data,
    output var  logic       rx_stop
);
    logic [7:0] m [0:31];
    logic [7:0] r [0:31];
    int         n, k, len;
    logic [1:0] cnt;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            n = 0;
            k = 0;
            len = 0;
            cnt <= 2'h0;
            tx_ready <= 1'b0;
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            rx_stop <= 1'b0;
        end else begin
            cnt <= cnt + 2'h1;
            tx_ready <= !slow || cnt[1];
            if (tx_valid && tx_ready) begin
                m[n] = tx_data;
                n = n + 1;
            end
            if (tx_valid && tx_ready && tx_last) begin
                if (m[0] == 8'h03) begin
                    len = 5 + 2 * MEMBERS;
                    r[0] = m[0];
                    r[1] = m[1];
                    for (int j = 0; j < MEMBERS; j++) begin
                        r[2 + 2 * j] = 8'hB1;
                        r[3 + 2 * j] = 8'hB2;
                    end
                    r[len - 3] = m[2];
                    r[len - 2] = 8'h67;
                    r[len - 1] = m[4] + 8'(MEMBERS);
                end else begin
                    len = n;
                    for (int j = 0; j < n; j++)
                        r[j] = m[j];
                    r[n - 1] = m[n - 1] + 8'(MEMBERS);
                end
                n = 0;
                k = 0;
            end
            if (rx_valid && rx_ready)
                k = k + 1;
            rx_valid <= k < len;
            // Released data line toggles so no stale byte is mistaken
            rx_data <= k < len ? r[k] : ~rx_data;
            rx_stop <= k == len - 1;
        end
    end
endmodule
`default_nettype wire

// file: sim/suq_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module suq_checker (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       cs_n,
    input wire logic       sclk,
    input wire logic       miso,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic       tx_last,
    input wire logic       rx_valid,
    input wire logic       rx_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_miso_idle: assert property (cs_n && $past(cs_n) |-> !miso)
        else $error("miso high between frames");
    a_miso_fall: assert property ($changed(miso) |->
        !$past(sclk) || cs_n || $past(cs_n)) else $error("miso moved early");
    a_tx_hold: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("tx byte dropped");
    a_tx_end: assert property (tx_valid && tx_ready && tx_last |=>
        !tx_valid) else $error("tx after last");
    a_tx_gap: assert property (tx_valid && tx_ready && !tx_last |->
        ##[1:2] tx_valid) else $error("tx gap too long");
    a_rx_full: assert property ($fell(rx_ready) |-> $past(rx_valid))
        else $error("rx_ready fell without push");
    a_rx_room: assert property ($rose(rx_ready) |->
        !$past(cs_n) || !$past(rstn, 2)) else $error("rx_ready rose idle");
    a_reset_quiet: assert property ($rose(rstn) |->
        !miso && !tx_valid && !rx_ready) else $error("outputs after reset");
    c_tx_last: cover property (tx_valid && tx_ready && tx_last);
    c_tx_stall: cover property (tx_valid && !tx_ready);
    c_rx_full: cover property ($fell(rx_ready));
endmodule
bind suq_top suq_checker u_chk (.clk, .rstn, .cs_n, .sclk, .miso,
    .tx_valid, .tx_ready, .tx_data, .tx_last, .rx_valid, .rx_ready);
`default_nettype wire

// file: sim/spi_uart_message_queue_commands_test.sv
`timescale 1ns/1ps
`default_nettype none
module spi_uart_message_queue_commands_test;
    logic clk = 0, rstn = 0, cs_n = 1, sclk = 0, mosi = 0, slow = 0;
    logic rx_err = 0;
    wire miso, tx_valid, tx_ready, tx_last, rx_valid, rx_ready, rx_stop;
    wire [7:0] tx_data, rx_data;
    int errors = 0, cmp_count = 0, cyc = 0;
    logic [7:0] ob [0:10], ib [0:10];
    logic [7:0] wm [0:10] = '{8'hC0, 8'h06, 8'h02, 8'h12, 8'hB1, 8'hB2,
        8'hC4, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] we [0:10] = '{8'h00, 8'h02, 8'h12, 8'hB1, 8'hB2, 8'hC4,
        8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] rm [0:10] = '{8'hC0, 8'h09, 8'h03, 8'h12, 8'h00, 8'hCB,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] re [0:10] = '{8'h00, 8'h03, 8'h12, 8'hB1, 8'hB2, 8'hB1,
        8'hB2, 8'h00, 8'h67, 8'h02, 8'h00};
    always #12.5 clk = ~clk;
    suq_top u_dut (.clk, .rstn, .cs_n, .sclk, .mosi, .miso, .tx_valid,
        .tx_ready, .tx_data, .tx_last, .rx_valid, .rx_ready, .rx_data,
        .rx_stop, .rx_err);
    suq_chain_model u_far (.clk, .rstn, .slow, .tx_valid, .tx_data,
        .tx_last, .tx_ready, .rx_valid, .rx_ready, .rx_data, .rx_stop);
    ////////////////////////////////////////////////////////////////////////
    task check(input string what, input logic [7:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task frame(input int n);
        cs_n = 0;
        repeat (2) @(negedge clk);
        for (int b = 0; b < n; b++)
            for (int i = 7; i >= 0; i--) begin
                sclk = 0;
                mosi = ob[b][i];
                repeat (2) @(negedge clk);
                ib[b][i] = miso;
                sclk = 1;
                repeat (2) @(negedge clk);
            end
        sclk = 0;
        repeat (2) @(negedge clk);
        cs_n = 1;
        repeat (3) @(negedge clk);
    endtask
    task ask(input logic [7:0] c, e);
        ob[0] = c;
        ob[1] = 8'h00;
        frame(2);
        check("reply", ib[1], e);
    endtask
    task run_msg(input int n, input logic [7:0] v [0:10]);
        for (int i = 0; i < n; i++)
            ob[i] = v[i];
        frame(n);
        ob[0] = 8'hC1;
        frame(n);
        for (int i = 1; i < n; i++)
            check("queue", ib[i], v[i]);
        ob[0] = 8'hB0;
        frame(1);
    endtask
    task drain(input int n, input logic [7:0] e [0:10]);
        ob[0] = 8'h93;
        frame(n);
        for (int i = 1; i < n; i++)
            check("message", ib[i], e[i]);
    endtask
    task t_reset;
        ask(8'h01, 8'h01);
        ask(8'h09, 8'h00);
        ask(8'hC1, 8'h00);
        ask(8'h55, 8'h00);
    endtask
    task t_write;
        slow = 1;
        rx_err = 1;
        run_msg(8, wm);
        ib[1] = 8'h00;
        ob[0] = 8'h01;
        ob[1] = 8'h00;
        for (int i = 0; i < 40 && ib[1][1] !== 1'b1; i++)
            frame(2);
        check("status", ib[1], 8'h02);
        drain(8, we);
        rx_err = 0;
        ask(8'h01, 8'h01);
        ask(8'h09, 8'h01);
        ob[0] = 8'h08;
        ob[1] = 8'h01;
        frame(2);
        ask(8'h09, 8'h00);
    endtask
    task t_read;
        slow = 0;
        run_msg(11, rm);
        for (int i = 0; i < 400 && rx_ready !== 1'b0; i++)
            @(negedge clk);
        check("rx_ready", {7'h00, rx_ready}, 8'h00);
        ask(8'h01, 8'h00);
        drain(11, re);
        ask(8'h09, 8'h00);
    endtask
    task close_out;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            errors++;
            close_out;
        end
    end
    initial begin
        repeat (2) @(negedge clk);
        rstn = 1;
        repeat (2) @(negedge clk);
        t_reset;
        t_write;
        t_read;
        close_out;
    end
endmodule
`default_nettype wire
